// ### hdl/cmd_port_pkg.sv
package cmd_port_pkg;
  // ==========================================================
  // Register map (word offsets on the host register port)
  localparam logic [1:0] OFF_CSW = 2'h0;
  localparam logic [1:0] OFF_BAL = 2'h1;  // Base + 2
  localparam logic [1:0] OFF_BBC = 2'h2;  // Base + 4
  // ==========================================================
  // Command/status word fields
  localparam int        POS_EXT_HI   = 15;
  localparam int        POS_EXT_LO   = 14;
  localparam int        POS_CMD_HI   = 13;
  localparam int        POS_CMD_LO   = 8;
  localparam int        POS_CMD_DONE = 7;
  localparam int        POS_CMD_COMPLETE_IRQ_EN   = 6;
  localparam int        POS_RX_DONE  = 5;
  localparam int        POS_RX_IE    = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  // ==========================================================
  // Command codes (octal in the description)
  localparam logic [5:0] CMD_NOP      = 6'o00;
  localparam logic [5:0] CMD_MI_LOOP  = 6'o01;
  localparam logic [5:0] CMD_IN_LOOP  = 6'o02;
  localparam logic [5:0] CMD_CLR_LOOP = 6'o03;
  localparam logic [5:0] CMD_PROMISC  = 6'o04;
  localparam logic [5:0] CMD_RESET    = 6'o77;
  // ==========================================================
  // Status codes
  localparam logic [3:0] ST_SUCCESS = 4'h0;    // 00
  localparam logic [3:0] ST_ILLEGAL = 4'h2;    // 02
  localparam logic [3:0] ST_NXM     = 4'hf;    // 17 octal
  // ==========================================================
  // Execution latency of one command in cycles
  localparam logic [3:0] EXEC_CYCLES = 4'h4;
  // Command categories
  typedef enum logic [3:0] {
    CAT_NONDMA  = 4'b0001,
    CAT_SYNC_RT = 4'b0010,
    CAT_SUPPLY  = 4'b0100,
    CAT_ASYNC   = 4'b1000
  } cmd_cat_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_t;
endpackage : cmd_port_pkg

// ### hdl/host_command_port_loopback.sv
// Operation
// R1 - Bits 15:14 written with the command give buffer address bits 17:16; read undefined.
// R2 - Writing command bits 13:8 starts that command; reading the field is undefined.
// R3 - Host waits for completion before a new command, except reset code 77.
// R4 - Completion flag bit 7 sets on finish, clears on low-byte read, ignores writes.
// R5 - Bit 6 enables completion interrupt; zero cancels any pending request.
// R6 - Receive-done bit 5 sets at end of receive DMA; low-byte read clears it.
// R7 - Bit 4 enables receive-done interrupt; zero cancels any pending request.
// R8 - Status bits 3:0 load the result as completion sets; writes ignored.
// R9 - Buffer address at offset 2 is write-only low 16 address bits.
// R10 - Host loads address and count before any DMA command.
// R11 - Byte count write-only; zero count on DMA command completes with status 17.
// R12 - Command 00 completes with status 02, illegal command.
// R13 - Command 01 enters module loopback, status 00, goes offline.
// R14 - Module loopback returns each frame bit-for-bit identical.
// R15 - In any data loopback the checksum generator is bypassed.
// R16 - Command 02 enters internal loopback, status 00, goes offline.
// R17 - Internal loopback returns frames only when they pass the receive filter.
// R18 - Pass/fail indicator on while internal loopback is active.
// R19 - Entering internal loopback leaves held receive frames intact.
// R20 - Command 03 leaves data loopback, status 00, indicator off.
// R21 - Command 04 enables promiscuous reception of all valid frames.
// R22 - Codes 50-57 supply, 30-37/70-76 sync return, 40-47 async return.
// R23 - Interrupt request while a completion flag and its enable are both set.
`timescale 1ns/1ps
`default_nettype none
module host_command_port_loopback
  import cmd_port_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Host register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_rd_low,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Receive DMA engine event
  input  wire logic        rx_dma_last,
  // Frame path control, indicator and interrupt
  output logic      [17:0] dma_addr,
  output logic      [15:0] dma_count,
  output logic             mi_loop_on,
  output logic             in_loop_on,
  output logic             offline,
  output logic             fcs_bypass,
  output logic             promisc_on,
  output logic             rx_fifo_flush,
  output logic             pass_fail_led,
  output logic             irq
);

  // ==========================================================
  // State
  typedef struct packed {
    exec_state_t st;
    logic [3:0]  cnt;
    logic [5:0]  cmd;
    logic [1:0]  ext;
    logic [15:0] bal;
    logic [15:0] bbc;
    logic        cmd_done;
    logic        cmd_complete_irq_en;
    logic        rx_done;
    logic        rx_ie;
    logic [3:0]  status;
    logic        mi_loop;
    logic        in_loop;
    logic        offl;
    logic        promisc;
    logic        flush;
    logic        irq;
    logic [15:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ==========================================================
  // Category decode, shared by execution and checks
  function automatic cmd_cat_t cat_of(input logic [5:0] c);
    if (c >= 6'o50 && c <= 6'o57)
      cat_of = CAT_SUPPLY;                                      // R22
    else if ((c >= 6'o30 && c <= 6'o37) || (c >= 6'o70 && c <= 6'o76))
      cat_of = CAT_SYNC_RT;                                     // R22
    else if (c >= 6'o40 && c <= 6'o47)
      cat_of = CAT_ASYNC;                                       // R22
    else
      cat_of = CAT_NONDMA;
  endfunction

  logic csw_wr;
  logic csw_rd_low;
  logic csw_reset;
  assign csw_wr     = reg_wr && reg_addr == OFF_CSW;
  assign csw_reset  = csw_wr && reg_wdata[POS_CMD_HI:POS_CMD_LO] == CMD_RESET;
  assign csw_rd_low = reg_rd && reg_rd_low && reg_addr == OFF_CSW;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.flush = 1'b0;
    // Low-byte read clears flags; a same-cycle set below still wins
    if (csw_rd_low)
    begin
      s_nxt.cmd_done = 1'b0;                                    // R4
      s_nxt.rx_done  = 1'b0;                                    // R6
    end
    if (rx_dma_last)
      s_nxt.rx_done = 1'b1;                                     // R6
    if (reg_wr && reg_addr == OFF_BAL)
      s_nxt.bal = reg_wdata;                                    // R9
    if (reg_wr && reg_addr == OFF_BBC)
      s_nxt.bbc = reg_wdata;                                    // R11
    if (csw_wr)
    begin
      // Enables only; flag and status bits ignore host writes
      s_nxt.cmd_complete_irq_en = reg_wdata[POS_CMD_COMPLETE_IRQ_EN];                     // R5
      s_nxt.rx_ie  = reg_wdata[POS_RX_IE];                      // R7
      // A new command is accepted when idle; reset any time
      if (s_r.st == ST_IDLE || reg_wdata[POS_CMD_HI:POS_CMD_LO] == CMD_RESET) // R3
      begin
        s_nxt.cmd = reg_wdata[POS_CMD_HI:POS_CMD_LO];           // R2
        s_nxt.ext = reg_wdata[POS_EXT_HI:POS_EXT_LO];           // R1
        s_nxt.st  = ST_EXEC;
        s_nxt.cnt = EXEC_CYCLES;
      end
    end
    unique case (s_r.st)
      ST_IDLE:
      begin
      end
      ST_EXEC:
      begin
        if (csw_reset)
        begin
          // Reset keeps the fresh count loaded above instead of counting on
        end
        else if (s_r.cnt != 4'h1)
          s_nxt.cnt = s_r.cnt - 4'h1;
        else
        begin
          s_nxt.st       = ST_IDLE;
          s_nxt.cmd_done = 1'b1;                                // R4
          s_nxt.status   = ST_SUCCESS;                          // R8
          if (cat_of(s_r.cmd) != CAT_NONDMA && s_r.bbc == 16'h0000)
            s_nxt.status = ST_NXM;                              // R11
          else
            unique case (s_r.cmd)
              CMD_NOP:      s_nxt.status = ST_ILLEGAL;          // R12
              CMD_MI_LOOP:
              begin
                s_nxt.mi_loop = 1'b1;                           // R13
                s_nxt.in_loop = 1'b0;
              end
              CMD_IN_LOOP:
              begin
                s_nxt.in_loop = 1'b1;                           // R16 R19
                s_nxt.mi_loop = 1'b0;
              end
              CMD_CLR_LOOP:
              begin
                s_nxt.mi_loop = 1'b0;                           // R20
                s_nxt.in_loop = 1'b0;
              end
              CMD_PROMISC:  s_nxt.promisc = 1'b1;               // R21
              CMD_RESET:
              begin
                s_nxt.mi_loop = 1'b0;
                s_nxt.in_loop = 1'b0;
                s_nxt.promisc = 1'b0;
                s_nxt.flush   = 1'b1;
              end
              default:
              begin
              end
            endcase
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Disabling an enable cancels the pending request at once
    s_nxt.irq = (s_nxt.cmd_done && s_nxt.cmd_complete_irq_en) || (s_nxt.rx_done && s_nxt.rx_ie); // R5 R7 R23
    // Offline level kept in its own flop so the pin needs no gate after the register
    s_nxt.offl = s_nxt.mi_loop | s_nxt.in_loop;                 // R13 R15 R16
    // Write-only fields read as zero here; reads of them are undefined anyway
    s_nxt.rdata = 16'h0000;
    // Flags show their value before this read clears them, else a poll would never see them
    if (reg_addr == OFF_CSW)
      s_nxt.rdata = {8'h00, s_r.cmd_done, s_r.cmd_complete_irq_en, s_r.rx_done, s_r.rx_ie, s_r.status}; // R4 R6
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s_r        <= '0;
      s_r.st     <= ST_IDLE;
      s_r.status <= STATUS_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Outputs straight from state flops
  assign reg_rdata     = s_r.rdata;
  assign dma_addr      = {s_r.ext, s_r.bal};                    // R1 R9
  assign dma_count     = s_r.bbc;
  assign mi_loop_on    = s_r.mi_loop;                           // R14
  assign in_loop_on    = s_r.in_loop;                           // R17
  assign offline       = s_r.offl;                              // R13 R16
  assign fcs_bypass    = s_r.offl;                              // R15
  assign promisc_on    = s_r.promisc;                           // R17 R21
  assign rx_fifo_flush = s_r.flush;
  assign pass_fail_led = s_r.in_loop;                           // R18 R20
  assign irq           = s_r.irq;                               // R23

  // ==========================================================
  // Checks
  property p_done_on_finish;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && !csw_wr) |=> s_r.cmd_done;
  endproperty
  a_done_on_finish: assert property (p_done_on_finish) else $error("completion flag not set"); // R4

  property p_read_clears;
    @(posedge clk_sys) disable iff (!nrst)
    (csw_rd_low && !rx_dma_last && s_r.st == ST_IDLE) |=> !s_r.rx_done && !s_r.cmd_done;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("low-byte read did not clear flags"); // R6

  property p_cmd_complete_irq_en_cancel;
    @(posedge clk_sys) disable iff (!nrst)
    (!s_r.cmd_complete_irq_en && !(s_r.rx_done && s_r.rx_ie)) |-> !s_r.irq;
  endproperty
  a_cmd_complete_irq_en_cancel: assert property (p_cmd_complete_irq_en_cancel) else $error("irq without enable"); // R5

  property p_rx_irq;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.rx_done && s_r.rx_ie) |-> s_r.irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing"); // R7

  property p_illegal;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && s_r.cmd == CMD_NOP && !csw_wr) |=> s_r.status == ST_ILLEGAL;
  endproperty
  a_illegal: assert property (p_illegal) else $error("command 00 not illegal"); // R12

  property p_nxm;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && !csw_wr && cat_of(s_r.cmd) != CAT_NONDMA && s_r.bbc == 16'h0000)
      |=> s_r.status == ST_NXM;
  endproperty
  a_nxm: assert property (p_nxm) else $error("zero count not reported"); // R11

  property p_cmd_latency;
    @(posedge clk_sys) disable iff (!nrst)
    (csw_wr && s_r.st == ST_IDLE) ##1 (!csw_wr)[*4] |=> s_r.cmd_done && s_r.st == ST_IDLE;
  endproperty
  a_cmd_latency: assert property (p_cmd_latency) else $error("command did not finish in time"); // R2

  property p_led;
    @(posedge clk_sys) disable iff (!nrst)
    pass_fail_led == in_loop_on && !(mi_loop_on && in_loop_on);
  endproperty
  a_led: assert property (p_led) else $error("indicator mismatch"); // R18

  property p_clr_loop;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && s_r.cmd == CMD_CLR_LOOP && !csw_wr)
      |=> !offline && !pass_fail_led && s_r.status == ST_SUCCESS;
  endproperty
  a_clr_loop: assert property (p_clr_loop) else $error("loopback not cleared"); // R20

  property p_mi_loop;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && s_r.cmd == CMD_MI_LOOP && !csw_wr)
      |=> mi_loop_on && !in_loop_on && offline && fcs_bypass && s_r.status == ST_SUCCESS;
  endproperty
  a_mi_loop: assert property (p_mi_loop) else $error("module loopback not entered"); // R13

  property p_in_loop;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && s_r.cmd == CMD_IN_LOOP && !csw_wr)
      |=> in_loop_on && !mi_loop_on && offline && pass_fail_led && !rx_fifo_flush;
  endproperty
  a_in_loop: assert property (p_in_loop) else $error("internal loopback not entered"); // R16

  property p_promisc;
    @(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_EXEC && s_r.cnt == 4'h1 && s_r.cmd == CMD_PROMISC && !csw_wr) |=> promisc_on;
  endproperty
  a_promisc: assert property (p_promisc) else $error("promiscuous mode not set"); // R21

  property p_reset_restart;
    @(posedge clk_sys) disable iff (!nrst)
    csw_reset |=> s_r.st == ST_EXEC && s_r.cmd == CMD_RESET && s_r.cnt == EXEC_CYCLES;
  endproperty
  a_reset_restart: assert property (p_reset_restart) else $error("reset command not taken"); // R3

  property p_ext_capture;
    @(posedge clk_sys) disable iff (!nrst)
    (csw_wr && s_r.st == ST_IDLE) |=> dma_addr[17:16] == $past(reg_wdata[POS_EXT_HI:POS_EXT_LO]);
  endproperty
  a_ext_capture: assert property (p_ext_capture) else $error("address extension not captured"); // R1

endmodule // host_command_port_loopback
`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host processor on the register port
module host_model (
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output logic      [1:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             reg_rd_low,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_addr   = 2'h3;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_rd_low = 1'b0;
    reg_wdata  = 16'h0000;
  end
  // Released data is inverted so stale values never look valid
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Low-byte read; data taken mid-cycle after the answer edge
  task automatic rd(input logic [1:0] a, output logic [15:0] q);
    @(posedge clk_sys);
    reg_addr   <= a;
    reg_rd     <= 1'b1;
    reg_rd_low <= 1'b1;
    @(posedge clk_sys);
    reg_rd     <= 1'b0;
    reg_rd_low <= 1'b0;
    @(negedge clk_sys);
    q = reg_rdata;
  endtask
  // Issue a command, then poll until completion before the next one
  task automatic cmd(input logic [15:0] w, output logic [15:0] q);
    int n;
    wr(2'h0, w);
    n = 0;
    q = 16'h0000;
    while (q[7] !== 1'b1 && n < 20)
    begin
      rd(2'h0, q);
      n++;
    end
  endtask
endmodule // host_model
`default_nettype wire

// ### test/tb_host_command_port_loopback.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the host command port
module tb_host_command_port_loopback;
  import cmd_port_pkg::*;
  logic        clk_sys, nrst, rx_dma_last, reg_wr, reg_rd, reg_rd_low;
  logic        flushed = 1'b0;
  logic [1:0]  reg_addr, ext;
  logic [15:0] reg_wdata, reg_rdata, dma_count, q, bal, bbc;
  logic [17:0] dma_addr;
  logic        mi_loop_on, in_loop_on, offline, fcs_bypass, promisc_on, rx_fifo_flush, pass_fail_led, irq;
  logic [31:0] seed;
  logic [5:0]  c;
  int          num_errors, n_checks, cyc;
  logic [5:0]  dma_codes [8] = '{6'o30, 6'o37, 6'o40, 6'o47, 6'o50, 6'o57, 6'o70, 6'o76};
  logic [5:0]  mode_codes [5] = '{CMD_NOP, CMD_MI_LOOP, CMD_IN_LOOP, CMD_PROMISC, CMD_CLR_LOOP};
  logic [4:0]  mode_exp [5] = '{5'b00000, 5'b10100, 5'b01110, 5'b01111, 5'b00001};

  host_model hm (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_low(reg_rd_low), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  host_command_port_loopback dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_low(reg_rd_low), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_dma_last(rx_dma_last), .dma_addr(dma_addr), .dma_count(dma_count), .mi_loop_on(mi_loop_on),
    .in_loop_on(in_loop_on), .offline(offline), .fcs_bypass(fcs_bypass), .promisc_on(promisc_on),
    .rx_fifo_flush(rx_fifo_flush), .pass_fail_led(pass_fail_led), .irq(irq));

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Zero count fails only commands that move data
  function automatic logic [3:0] exp_st(input logic [5:0] k, input logic [15:0] n);
    if (k == CMD_NOP)
      return ST_ILLEGAL;
    if (n == 16'h0000 && (k[5:3] inside {3'o3, 3'o4, 3'o5} || (k[5:3] == 3'o7 && k != CMD_RESET)))
      return ST_NXM;
    return ST_SUCCESS;
  endfunction
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse_rx();
    @(posedge clk_sys);
    rx_dma_last <= 1'b1;
    @(posedge clk_sys);
    rx_dma_last <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Clock, timeout ceiling and flush watcher
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rx_fifo_flush === 1'b1)
      flushed = 1'b1;
    if (cyc == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    rx_dma_last = 1'b0;
    seed = 32'h4918;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    hm.rd(OFF_CSW, q);
    chk(q, 0);
    chk(irq, 0);
    hm.rd(2'h3, q);
    chk(q, 0);
    // Data-moving codes, alternating zero and random counts
    for (int i = 0; i < 8; i++)
    begin
      bal = 16'(rnd());
      ext = 2'(rnd());
      bbc = i[0] ? 16'h0000 : 16'(rnd() | 32'h1);
      hm.wr(OFF_BAL, bal);
      hm.wr(OFF_BBC, bbc);
      hm.cmd({ext, dma_codes[i], 8'h00}, q);
      chk(q[3:0], exp_st(dma_codes[i], bbc));
      chk(dma_addr, {ext, bal});
      chk(dma_count, bbc);
    end
    hm.rd(OFF_BAL, q);
    chk(q, 0);
    // Mode commands in a chain that exercises every switch
    for (int i = 0; i < 5; i++)
    begin
      c = mode_codes[i];
      hm.cmd({2'b00, c, 8'h00}, q);
      chk(q[3:0], exp_st(c, 16'h0001));
      chk({mi_loop_on, in_loop_on, fcs_bypass, pass_fail_led, promisc_on}, mode_exp[i]);
      if (c != CMD_CLR_LOOP)
        chk(offline, mode_exp[i][4] | mode_exp[i][3]);
    end
    chk(flushed, 0);
    // Completion interrupt raised, then cancelled by a zero enable
    hm.wr(OFF_CSW, {2'b00, CMD_PROMISC, 8'h40});
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(irq, 1);
    hm.wr(OFF_CSW, {2'b00, CMD_PROMISC, 8'h00});
    repeat (1) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(irq, 0);
    // Let that command finish before the next one; its flag sets with no request
    repeat (4) @(posedge clk_sys);
    hm.rd(OFF_CSW, q);
    chk(q[7], 1);
    chk(irq, 0);
    hm.cmd({2'b00, CMD_PROMISC, 8'hbf}, q);
    chk(q[6:0], 7'h10);
    hm.rd(OFF_CSW, q);
    chk(q[7], 0);
    chk(irq, 0);
    // Receive-done with enable, cleared by a read
    pulse_rx();
    chk(irq, 1);
    hm.rd(OFF_CSW, q);
    chk(q[5], 1);
    hm.rd(OFF_CSW, q);
    chk(q[5], 0);
    hm.cmd({2'b00, CMD_PROMISC, 8'h00}, q);
    pulse_rx();
    chk(irq, 0);
    // Reset code accepted while a command is still running
    hm.wr(OFF_CSW, {2'b00, CMD_MI_LOOP, 8'h00});
    hm.cmd({2'b00, CMD_RESET, 8'h00}, q);
    chk({q[7], q[3:0]}, 5'h10);
    chk({flushed, mi_loop_on, promisc_on}, 3'b100);
    wrap_up();
  end
endmodule // tb_host_command_port_loopback
`default_nettype wire
